// ---- bb_cfg_pkg.sv ----
// Package with register map, field layout, reset values and types of the baseband configuration bank
//
// Overview of operation
// - State-2 integrator constant, four bits, resets to 0xE, used in states 2 and 3.
// - State-1 integrator constant, four bits, resets to 0x5, used in state 1.
// - State-0 integrator constant, four bits, resets to 0x3, used in state 0.
// - Common-mode bit: clear picks 1.2 V, set picks 1.4 V output level.
// - Bit 10 set swaps positive and negative legs of receive Q output.
// - Bit 9 set swaps positive and negative legs of receive I output.
// - Filter code: 000 fifth-order, 010 seventh-order, 111 GSM, others reserved.
// - Gain calibration field, 1 dB per step, subtracted in receive gain.
// - Bit 0 picks offset modulator oversampling: set 4x, clear 2x default.
// - Transmit I option: normal, swap, zero input, or DC offset carrier.
// - Transmit Q option: normal, swap, zero input, or DC offset carrier.
// - Blanking select sets transmit blanking interval around each gain change.
`default_nettype none
package bb_cfg_pkg;
    // ------------------------------------------------------------
    // Register byte addresses (printed offsets are word indices)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_INTEG = 8'h0E;
    localparam logic [7:0] IDX_RXOUT = 8'h0F;
    localparam logic [7:0] IDX_TXIN = 8'h15;
    localparam int ADDR_W = 10;
    localparam logic [ADDR_W-1:0] ADDR_INTEG = {IDX_INTEG, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_RXOUT = {IDX_RXOUT, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_TXIN = {IDX_TXIN, 2'b00};
    localparam int REG_W = 16;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int INT2_LSB = 8;
    localparam int INT1_LSB = 4;
    localparam int INT0_LSB = 0;
    localparam int VCM_BIT = 11;
    localparam int SWQ_BIT = 10;
    localparam int SWI_BIT = 9;
    localparam int BW_LSB = 6;
    localparam int GCAL_LSB = 1;
    localparam int OSR_BIT = 0;
    localparam int TXI_LSB = 11;
    localparam int TXQ_LSB = 9;
    localparam int BLNK_LSB = 7;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [3:0] INT2_RST = 4'hE;
    localparam logic [3:0] INT1_RST = 4'h5;
    localparam logic [3:0] INT0_RST = 4'h3;
    localparam logic [4:0] GCAL_RST = 5'h08;
    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        BW_WCDMA5 = 3'h0,
        BW_WCDMA7 = 3'h2,
        BW_GSM = 3'h7
    } rx_bw_t;
    typedef enum logic [1:0] {
        TXOPT_NORMAL = 2'h0,
        TXOPT_SWAP = 2'h1,
        TXOPT_ZERO = 2'h2,
        TXOPT_DC = 2'h3
    } tx_opt_t;
    typedef enum logic [1:0] {
        OL_STATE0 = 2'h0,
        OL_STATE1 = 2'h1,
        OL_STATE2 = 2'h2,
        OL_STATE3 = 2'h3
    } ol_state_t;
    typedef struct packed {
        logic [3:0] integ_const_state_two;
        logic [3:0] integ_const_state_one;
        logic [3:0] integ_const_state_zero;
    } integ_cfg_t;
    typedef struct packed {
        logic vcm_high;
        logic swap_q;
        logic swap_i;
        logic [2:0] bw_mode;
        logic [4:0] gain_cal;
        logic osr_4x;
    } rx_cfg_t;
    typedef struct packed {
        logic [1:0] i_opt;
        logic [1:0] q_opt;
        logic [1:0] blank_sel;
    } tx_cfg_t;
    typedef struct packed {
        logic pos;
        logic neg;
    } diff_t;
endpackage
`default_nettype wire

// ---- bb_leg_swap.sv ----
// Differential leg exchanger for one receive baseband path
`default_nettype none
module bb_leg_swap
    import bb_cfg_pkg::*;
(
    input wire logic swap_i,
    input wire diff_t in_i,
    output diff_t out_o
);
    assign out_o.pos = swap_i ? in_i.neg : in_i.pos;
    assign out_o.neg = swap_i ? in_i.pos : in_i.neg;
endmodule
`default_nettype wire

// ---- bb_cfg_regs.sv ----
// Baseband configuration register bank with classic Wishbone slave and static analogue controls
`default_nettype none
module bb_cfg_regs
    import bb_cfg_pkg::*;
#(
    parameter int GAIN_W = 7
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADDR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Offset loop
    input wire ol_state_t ol_state_i,
    output logic [3:0] integ_const_o,
    output logic osr_4x_o,
    // Receive baseband output
    input wire diff_t rx_quad_i,
    input wire diff_t rx_inphase_i,
    output logic rx_quad_out_pos_o,
    output logic rx_quad_out_neg_o,
    output logic rx_inphase_out_pos_o,
    output logic rx_inphase_out_neg_o,
    output logic vcm_high_o,
    output logic [2:0] bw_mode_o,
    output logic bw_reserved_o,
    // Receive gain
    input wire logic [GAIN_W-1:0] rx_gain_req_i,
    output logic [GAIN_W-1:0] rx_gain_o,
    // Transmit input options
    output tx_cfg_t tx_cfg_o
);
    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire logic req = cyc_i & stb_i & ~ack_o;
    wire logic hit_int = adr_i == ADDR_INTEG;
    wire logic hit_rx = adr_i == ADDR_RXOUT;
    wire logic hit_tx = adr_i == ADDR_TXIN;
    wire logic wr = req & we_i;
    // Registers are 16 bits wide, so only the two low byte lanes carry data
    wire logic [REG_W-1:0] wmask = {{8{sel_i[1]}}, {8{sel_i[0]}}};

    integ_cfg_t integ_q;
    rx_cfg_t rx_q;
    tx_cfg_t tx_q;

    wire logic [REG_W-1:0] integ_word = {4'h0, integ_q};
    wire logic [REG_W-1:0] rx_word = {4'h0, rx_q};
    wire logic [REG_W-1:0] tx_word = {3'h0, tx_q, 7'h00};

    function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old, input logic [REG_W-1:0] nw,
                                               input logic [REG_W-1:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction

    wire logic [REG_W-1:0] integ_new = merge(integ_word, dat_i[REG_W-1:0], wmask);
    wire logic [REG_W-1:0] rx_new = merge(rx_word, dat_i[REG_W-1:0], wmask);
    wire logic [REG_W-1:0] tx_new = merge(tx_word, dat_i[REG_W-1:0], wmask);

    // Unmapped addresses still ack and read zero, so a stray access never hangs the bus
    wire logic [REG_W-1:0] rd_word = hit_int ? integ_word :
                                     hit_rx ? rx_word :
                                     hit_tx ? tx_word : 16'h0000;

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            integ_q <= '{INT2_RST, INT1_RST, INT0_RST};
        end else if (wr && hit_int) begin
            integ_q.integ_const_state_two <= integ_new[INT2_LSB +: 4];
            integ_q.integ_const_state_one <= integ_new[INT1_LSB +: 4];
            integ_q.integ_const_state_zero <= integ_new[INT0_LSB +: 4];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_q <= '{1'b0, 1'b0, 1'b0, BW_WCDMA5, GCAL_RST, 1'b0};
        end else if (wr && hit_rx) begin
            rx_q.vcm_high <= rx_new[VCM_BIT];
            rx_q.swap_q <= rx_new[SWQ_BIT];
            rx_q.swap_i <= rx_new[SWI_BIT];
            rx_q.bw_mode <= rx_new[BW_LSB +: 3];
            rx_q.gain_cal <= rx_new[GCAL_LSB +: 5];
            rx_q.osr_4x <= rx_new[OSR_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_q <= '{TXOPT_NORMAL, TXOPT_NORMAL, 2'h0};
        end else if (wr && hit_tx) begin
            tx_q.i_opt <= tx_new[TXI_LSB +: 2];
            tx_q.q_opt <= tx_new[TXQ_LSB +: 2];
            tx_q.blank_sel <= tx_new[BLNK_LSB +: 2];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= req;
            dat_o <= (req && !we_i) ? {16'h0000, rd_word} : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Offset loop constant selection
    // ------------------------------------------------------------
    logic [3:0] integ_sel;
    always_comb begin
        unique case (ol_state_i)
            OL_STATE2: integ_sel = integ_q.integ_const_state_two;
            OL_STATE1: integ_sel = integ_q.integ_const_state_one;
            OL_STATE0: integ_sel = integ_q.integ_const_state_zero;
            // State 3 constant lives in a neighbouring register; hold the state-2 value
            OL_STATE3: integ_sel = integ_q.integ_const_state_two;
        endcase
    end

    // ------------------------------------------------------------
    // Receive gain: request minus calibration plus mode offset
    // ------------------------------------------------------------
    localparam logic [GAIN_W:0] MODE_OFS_WCDMA = (GAIN_W + 1)'(8'h08);
    localparam logic [GAIN_W:0] MODE_OFS_GSM = (GAIN_W + 1)'(8'h11);
    wire logic gsm = rx_q.bw_mode == BW_GSM;
    wire logic [GAIN_W:0] gain_sum = {1'b0, rx_gain_req_i} + (gsm ? MODE_OFS_GSM : MODE_OFS_WCDMA);
    wire logic [GAIN_W:0] gain_cal_ext = {{(GAIN_W - 4){1'b0}}, rx_q.gain_cal};
    // Clamp at zero rather than wrap when calibration reaches or exceeds the request plus mode offset
    wire logic [GAIN_W:0] gain_diff = (gain_sum > gain_cal_ext) ? gain_sum - gain_cal_ext : '0;
    wire logic [GAIN_W-1:0] gain_next = gain_diff[GAIN_W] ? {GAIN_W{1'b1}} : gain_diff[GAIN_W-1:0];

    // ------------------------------------------------------------
    // Receive output leg swapping
    // ------------------------------------------------------------
    diff_t q_sw;
    diff_t i_sw;
    bb_leg_swap u_swap_q (
        .swap_i(rx_q.swap_q),
        .in_i(rx_quad_i),
        .out_o(q_sw)
    );
    bb_leg_swap u_swap_i (
        .swap_i(rx_q.swap_i),
        .in_i(rx_inphase_i),
        .out_o(i_sw)
    );

    wire logic bw_rsv = !(rx_q.bw_mode == BW_WCDMA5 || rx_q.bw_mode == BW_WCDMA7 || gsm);

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            integ_const_o <= INT0_RST;
            osr_4x_o <= 1'b0;
            rx_quad_out_pos_o <= 1'b0;
            rx_quad_out_neg_o <= 1'b0;
            rx_inphase_out_pos_o <= 1'b0;
            rx_inphase_out_neg_o <= 1'b0;
            vcm_high_o <= 1'b0;
            bw_mode_o <= BW_WCDMA5;
            bw_reserved_o <= 1'b0;
            rx_gain_o <= '0;
            tx_cfg_o <= '0;
        end else begin
            integ_const_o <= integ_sel;
            osr_4x_o <= rx_q.osr_4x;
            rx_quad_out_pos_o <= q_sw.pos;
            rx_quad_out_neg_o <= q_sw.neg;
            rx_inphase_out_pos_o <= i_sw.pos;
            rx_inphase_out_neg_o <= i_sw.neg;
            vcm_high_o <= rx_q.vcm_high;
            bw_mode_o <= rx_q.bw_mode;
            bw_reserved_o <= bw_rsv;
            rx_gain_o <= gain_next;
            tx_cfg_o <= tx_q;
        end
    end
endmodule
`default_nettype wire

// ---- bb_cfg_regs_properties.sv ----
// Concurrent checks on the ports of the baseband configuration bank
`default_nettype none
module bb_cfg_regs_chk
    import bb_cfg_pkg::*;
#(
    parameter int GAIN_W = 7
)
(
    // Clock, reset and bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADDR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic ack_o,
    // Controls
    input wire ol_state_t ol_state_i,
    input wire logic [3:0] integ_const_o,
    input wire logic osr_4x_o,
    input wire diff_t rx_quad_i,
    input wire diff_t rx_inphase_i,
    input wire logic rx_quad_out_pos_o,
    input wire logic rx_quad_out_neg_o,
    input wire logic rx_inphase_out_pos_o,
    input wire logic rx_inphase_out_neg_o,
    input wire logic vcm_high_o,
    input wire logic [2:0] bw_mode_o,
    input wire logic bw_reserved_o,
    input wire logic [GAIN_W-1:0] rx_gain_req_i,
    input wire logic [GAIN_W-1:0] rx_gain_o,
    input wire tx_cfg_t tx_cfg_o
);
    // ------------------------------------------------------------
    // Shadow copies of the registers, built from bus writes
    // ------------------------------------------------------------
    logic [15:0] ig_q;
    logic [15:0] rx_q;
    logic [15:0] tx_q;
    wire logic take = cyc_i && stb_i && we_i && !ack_o;
    wire logic [15:0] m = {{8{sel_i[1]}}, {8{sel_i[0]}}};
    wire logic [15:0] d = dat_i[15:0] & m;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ig_q <= 16'h0E53;
            rx_q <= 16'h0010;
            tx_q <= 16'h0000;
        end else if (take) begin
            if (adr_i == ADDR_INTEG) ig_q <= (ig_q & ~m) | d;
            if (adr_i == ADDR_RXOUT) rx_q <= (rx_q & ~m) | d;
            if (adr_i == ADDR_TXIN) tx_q <= (tx_q & ~m) | d;
        end
    end
    wire logic [3:0] ic = ol_state_i == OL_STATE0 ? ig_q[3:0] : ol_state_i == OL_STATE1 ? ig_q[7:4] : ig_q[11:8];
    wire diff_t qx = rx_q[10] ? {rx_quad_i.neg, rx_quad_i.pos} : rx_quad_i;
    wire diff_t ix = rx_q[9] ? {rx_inphase_i.neg, rx_inphase_i.pos} : rx_inphase_i;
    wire logic [3:0] bwc = {rx_q[8:6], !(rx_q[8:6] inside {3'h0, 3'h2, 3'h7})};
    wire logic osr_c = rx_q[0];
    wire logic vcm_c = rx_q[11];
    wire logic [5:0] txc = tx_q[12:7];
    wire logic [8:0] gs = 9'(rx_gain_req_i) + (rx_q[8:6] == 3'h7 ? 9'h011 : 9'h008);
    wire logic [8:0] gd = gs - 9'(rx_q[5:1]);
    wire logic [GAIN_W-1:0] ge = gs < 9'(rx_q[5:1]) ? '0 : gd > 9'((1 << GAIN_W) - 1) ? '1 : GAIN_W'(gd);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_take; cyc_i && stb_i && !ack_o; endsequence
    sequence s_pulse; ack_o ##1 !ack_o; endsequence
    property p_ack; s_take |=> s_pulse; endproperty
    a_ack: assert property (p_ack) else $error("bus answer missing or too long");
    property p_rst; disable iff (1'b0) rst_i |=> integ_const_o == 4'h3 && tx_cfg_o == '0 && !osr_4x_o; endproperty
    a_rst: assert property (p_rst) else $error("reset values wrong");
    property p_int; !$past(rst_i) |-> integ_const_o == $past(ic); endproperty
    a_int: assert property (p_int) else $error("integrator constant wrong");
    property p_vcm; !$past(rst_i) |-> vcm_high_o == $past(vcm_c); endproperty
    a_vcm: assert property (p_vcm) else $error("common mode select wrong");
    property p_swq; !$past(rst_i) |-> {rx_quad_out_pos_o, rx_quad_out_neg_o} == $past(qx); endproperty
    a_swq: assert property (p_swq) else $error("quadrature legs wrong");
    property p_swi; !$past(rst_i) |-> {rx_inphase_out_pos_o, rx_inphase_out_neg_o} == $past(ix); endproperty
    a_swi: assert property (p_swi) else $error("in-phase legs wrong");
    property p_bw; !$past(rst_i) |-> {bw_mode_o, bw_reserved_o} == $past(bwc); endproperty
    a_bw: assert property (p_bw) else $error("filter mode wrong");
    property p_gain; !$past(rst_i) |-> rx_gain_o == $past(ge); endproperty
    a_gain: assert property (p_gain) else $error("receive gain wrong");
    property p_osr; !$past(rst_i) |-> osr_4x_o == $past(osr_c); endproperty
    a_osr: assert property (p_osr) else $error("oversampling select wrong");
    property p_tx; !$past(rst_i) |-> tx_cfg_o == $past(txc); endproperty
    a_tx: assert property (p_tx) else $error("transmit options wrong");
endmodule
bind bb_cfg_regs bb_cfg_regs_chk #(.GAIN_W(GAIN_W)) u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o),
    .ol_state_i(ol_state_i), .integ_const_o(integ_const_o), .osr_4x_o(osr_4x_o), .rx_quad_i(rx_quad_i),
    .rx_inphase_i(rx_inphase_i), .rx_quad_out_pos_o(rx_quad_out_pos_o), .rx_quad_out_neg_o(rx_quad_out_neg_o),
    .rx_inphase_out_pos_o(rx_inphase_out_pos_o), .rx_inphase_out_neg_o(rx_inphase_out_neg_o),
    .vcm_high_o(vcm_high_o), .bw_mode_o(bw_mode_o), .bw_reserved_o(bw_reserved_o),
    .rx_gain_req_i(rx_gain_req_i), .rx_gain_o(rx_gain_o), .tx_cfg_o(tx_cfg_o));
`default_nettype wire

// ---- testbench.sv ----
// Self-checking testbench for the baseband configuration bank
`default_nettype none
module testbench import bb_cfg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [ADDR_W-1:0] adr_i = '0;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, rq;
    ol_state_t ol_state_i = OL_STATE0;
    diff_t rx_quad_i = 2'h2, rx_inphase_i = 2'h1;
    logic [6:0] rx_gain_req_i = 7'h14, rx_gain_o;
    logic [3:0] integ_const_o;
    logic [2:0] bw_mode_o;
    logic ack_o, osr_4x_o, qp, qn, ip, in_n, vcm_high_o, bw_reserved_o;
    tx_cfg_t tx_cfg_o;
    int fails = 0, comparisons = 0;
    bb_cfg_regs #(.GAIN_W(7)) dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .ol_state_i(ol_state_i),
        .integ_const_o(integ_const_o), .osr_4x_o(osr_4x_o), .rx_quad_i(rx_quad_i), .rx_inphase_i(rx_inphase_i),
        .rx_quad_out_pos_o(qp), .rx_quad_out_neg_o(qn), .rx_inphase_out_pos_o(ip), .rx_inphase_out_neg_o(in_n),
        .vcm_high_o(vcm_high_o), .bw_mode_o(bw_mode_o), .bw_reserved_o(bw_reserved_o),
        .rx_gain_req_i(rx_gain_req_i), .rx_gain_o(rx_gain_o), .tx_cfg_o(tx_cfg_o));
    initial forever #5 clk_i = ~clk_i;
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task stop_test;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task bus(input logic w, input logic [9:0] a, input logic [15:0] d, input logic [1:0] s);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {16'h0, d};
        sel_i <= {2'h0, s};
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        rq = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    task rd(input logic [9:0] a, input logic [15:0] e);
        bus(1'b0, a, 16'h0, 2'h3);
        chk(rq[15:0], e);
    endtask
    // Outputs are registered one edge behind the stored value
    task settle;
        repeat (2) @(posedge clk_i);
        #1;
    endtask
    task states(input logic [15:0] v);
        for (int s = 0; s < 4; s++) begin
            @(posedge clk_i);
            ol_state_i <= ol_state_t'(s);
            settle();
            chk(16'(integ_const_o), 16'(s == 0 ? v[3:0] : s == 1 ? v[7:4] : v[11:8]));
        end
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset;
        rd(ADDR_INTEG, 16'h0E53);
        rd(ADDR_RXOUT, 16'h0010);
        rd(ADDR_TXIN, 16'h0000);
        states(16'h0E53);
    endtask
    task t_integ;
        bus(1'b1, ADDR_INTEG, 16'hF7A1, 2'h3);
        rd(ADDR_INTEG, 16'h07A1);
        states(16'h07A1);
        bus(1'b1, ADDR_INTEG, 16'h0C2B, 2'h2);
        rd(ADDR_INTEG, 16'h0CA1);
        states(16'h0CA1);
    endtask
    task automatic t_rx;
        logic [15:0] rxv [4] = '{16'h0810, 16'h04B1, 16'h03D0, 16'h0F42};
        logic [6:0] req [4] = '{7'h14, 7'h00, 7'h7F, 7'h7F};
        int g;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_i);
            rx_gain_req_i <= req[k];
            bus(1'b1, ADDR_RXOUT, rxv[k], 2'h3);
            rd(ADDR_RXOUT, rxv[k] & 16'h0FFF);
            settle();
            g = int'(req[k]) + (rxv[k][8:6] == 3'h7 ? 17 : 8) - int'(rxv[k][5:1]);
            g = g < 0 ? 0 : g > 127 ? 127 : g;
            chk(16'(rx_gain_o), 16'(g));
            chk(16'(vcm_high_o), 16'(rxv[k][11]));
            chk(16'({qp, qn}), rxv[k][10] ? 16'h1 : 16'h2);
            chk(16'({ip, in_n}), rxv[k][9] ? 16'h2 : 16'h1);
            chk(16'(bw_mode_o), 16'(rxv[k][8:6]));
            chk(16'(bw_reserved_o), 16'(k == 3));
            chk(16'(osr_4x_o), 16'(rxv[k][0]));
        end
        // Calibration unused: software parks the field at its neutral value
        bus(1'b1, ADDR_RXOUT, 16'h0010, 2'h3);
        rd(ADDR_RXOUT, 16'h0010);
    endtask
    task t_tx;
        logic [15:0] v;
        for (int k = 0; k < 4; k++) begin
            v = 16'(k) << 11 | 16'(3 - k) << 9 | 16'(k) << 7;
            bus(1'b1, ADDR_TXIN, v | 16'h007F, 2'h3);
            rd(ADDR_TXIN, v);
            settle();
            chk(16'(tx_cfg_o), 16'({2'(k), 2'(3 - k), 2'(k)}));
        end
        bus(1'b1, 10'h040, 16'hFFFF, 2'h3);
        rd(10'h040, 16'h0000);
        rd(ADDR_TXIN, v);
    endtask
    initial begin
        #200000;
        fails++;
        stop_test();
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_integ();
        t_rx();
        t_tx();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        stop_test();
    end
endmodule
`default_nettype wire
